// File: core/pbop_pkg.sv
package pbop_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int unsigned PBOP_ADDR_W = 16;
   localparam int unsigned PBOP_DATA_W = 8;
   localparam logic [15:0] PBOP_OFS_CLK0 = 16'h0500;
   localparam logic [15:0] PBOP_OFS_CLK1 = 16'h0501;
   localparam logic [15:0] PBOP_OFS_FMT0 = 16'h0502;
   localparam logic [15:0] PBOP_OFS_FMT1 = 16'h0503;
   localparam logic [15:0] PBOP_OFS_SYNC = 16'h0504;
   localparam logic [15:0] PBOP_OFS_ALARM = 16'h0506;

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [6:0] PBOP_RST_CLK = 7'h00;
   localparam logic [5:0] PBOP_RST_FMT = 6'h00;
   localparam logic [7:0] PBOP_RST_SYNC = 8'h77;
   localparam logic [1:0] PBOP_RST_ALARM = 2'h0;

   // ****************************************************************
   // Unit layout and counts
   // ****************************************************************
   localparam int unsigned PBOP_PORTS = 2;
   localparam int unsigned PBOP_DIV_W = 5;
   localparam int unsigned PBOP_BYTE_BITS = 8;
   localparam int unsigned PBOP_UNIT_MAX = 10;
   localparam int unsigned PBOP_LEN_W = 4;
   localparam logic [1:0] PBOP_FFLAG_ZERO = 2'h0;
   localparam logic [1:0] PBOP_FFLAG_TDM = 2'h1;

   // ****************************************************************
   // Carriers; field order follows the register bit order
   // ****************************************************************
   typedef struct packed {
      logic [PBOP_DIV_W-1:0] bit_clock_divisor;
      logic bit_clock_invert;
      logic bit_clock_free_run;
   } pbop_clk_cfg_s;

   typedef struct packed {
      logic [1:0] frame_flag_mode;
      logic frame_flag_enable;
      logic parity_sense;
      logic parity_enable;
      logic bit_order_select;
   } pbop_fmt_s;

   typedef struct packed {
      logic sync_error_pin_select;
      logic tdm_strobe_timing;
      logic channel_strobe_timing;
      logic byte_strobe_timing;
   } pbop_sync_s;

   typedef struct packed {
      logic [PBOP_BYTE_BITS-1:0] data;
      logic first_tdm;
      logic first_prc;
      logic error;
   } pbop_byte_s;

   typedef struct packed {
      logic bit_clock;
      logic data;
      logic byte_strobe;
      logic channel_frame_strobe;
      logic tdm_frame_strobe;
      logic frame_sync_or_error_pin;
   } pbop_pins_s;

endpackage : pbop_pkg

// File: core/pbop_bit_clock.sv
`timescale 1ns/10ps
`default_nettype none
module pbop_bit_clock
   import pbop_pkg::*;
#(
   parameter int unsigned DIV_W = PBOP_DIV_W
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [DIV_W-1:0] divisor,
   input wire logic invert,
   input wire logic run,
   output logic bit_clock,
   output logic change_en,
   output logic sample_en
);
   logic [DIV_W-1:0] cnt_reg;
   logic level_reg;
   logic running_reg;
   logic tick;

   // ****************************************************************
   // Half period of divisor+1 cycles
   // ****************************************************************
   assign tick = running_reg && run && (cnt_reg == divisor);

   always_ff @(posedge clk_sys)
   begin
      if (rst || !run)
      begin
         cnt_reg <= '0;
         level_reg <= 1'b0;
      end
      else if (tick)
      begin
         cnt_reg <= '0;
         level_reg <= !level_reg;
      end
      else if (running_reg)
      begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         running_reg <= 1'b0;
      else
         running_reg <= run;
   end

   // Start cycle counts as a falling edge so data leads the first rise
   assign change_en = (run && !running_reg) || (tick && level_reg);
   assign sample_en = tick && !level_reg;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         bit_clock <= 1'b0;
      else if (!run)
         bit_clock <= invert;
      else
         bit_clock <= (tick ? !level_reg : level_reg) ^ invert;
   end

endmodule : pbop_bit_clock
`default_nettype wire

// File: core/pbop_unit_builder.sv
`timescale 1ns/10ps
`default_nettype none
module pbop_unit_builder
   import pbop_pkg::*;
(
   input wire pbop_pkg::pbop_fmt_s fmt,
   input wire pbop_pkg::pbop_byte_s byte_in,
   output logic [PBOP_UNIT_MAX-1:0] unit_bits,
   output logic [PBOP_LEN_W-1:0] unit_len
);
   logic [PBOP_BYTE_BITS-1:0] ordered;
   logic parity_bit;
   logic flag_bit;

   // ****************************************************************
   // Bit order; index 0 goes out first
   // ****************************************************************
   for (genvar i = 0; i < PBOP_BYTE_BITS; i++)
   begin : g_order
      assign ordered[i] = fmt.bit_order_select ? byte_in.data[i] :
                          byte_in.data[PBOP_BYTE_BITS-1-i];
   end

   assign parity_bit = (^byte_in.data) ^ fmt.parity_sense;

   always_comb
   begin
      if (fmt.frame_flag_mode == PBOP_FFLAG_ZERO)
         flag_bit = 1'b0;
      else if (fmt.frame_flag_mode == PBOP_FFLAG_TDM)
         flag_bit = byte_in.first_tdm;
      else
         flag_bit = byte_in.first_prc;
   end

   // ****************************************************************
   // Data, then parity, then flag
   // ****************************************************************
   always_comb
   begin
      unit_bits = {2'b00, ordered};
      unit_len = 4'(PBOP_BYTE_BITS);
      if (fmt.parity_enable)
      begin
         unit_bits[PBOP_BYTE_BITS] = parity_bit;
         unit_len = 4'(PBOP_BYTE_BITS + 1);
      end
      if (fmt.frame_flag_enable)
      begin
         if (fmt.parity_enable)
            unit_bits[PBOP_BYTE_BITS+1] = flag_bit;
         else
            unit_bits[PBOP_BYTE_BITS] = flag_bit;
         unit_len = unit_len + 4'h1;
      end
   end

endmodule : pbop_unit_builder
`default_nettype wire

// File: core/pbop_output_port.sv
// Overview of operation
// - Bit clock is master clock over 2*(divisor+1)
// - Invert bit sets output clock polarity inverted
// - Free-run off: clock toggles only while a byte is pending or shifting
// - Flag mode picks zero, first TDM, or PRC
// - Flag enable appends frame flag to each byte
// - Parity sense chooses even or odd parity
// - Parity enable appends parity bit per unit
// - Bit order selects MSB or LSB first
// - Pin select: TDM sync or error flag
// - TDM strobe on first bit or one earlier
// - Channel strobe on first bit or one earlier
// - Byte strobe on first bit or one earlier
// - Per-port alarm bit flags transmission errors
// - Reading alarm register clears both bits
// - Two independent ports, one shared sync register
`timescale 1ns/10ps
`default_nettype none
module pbop_output_port
   import pbop_pkg::*;
#(
   parameter int unsigned PORTS = PBOP_PORTS
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [PBOP_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [PBOP_DATA_W-1:0] reg_wdata,
   output logic [PBOP_DATA_W-1:0] reg_rdata,
   input wire logic [PORTS-1:0] byte_valid,
   output logic [PORTS-1:0] byte_ready,
   input wire pbop_pkg::pbop_byte_s [PORTS-1:0] byte_in,
   output pbop_pkg::pbop_pins_s [PORTS-1:0] port_pins
);
   import pbop_pkg::*;

   // ****************************************************************
   // Configuration and status registers
   // ****************************************************************
   pbop_clk_cfg_s [PORTS-1:0] clk_cfg_reg;
   pbop_fmt_s [PORTS-1:0] fmt_reg;
   pbop_sync_s [PORTS-1:0] sync_reg;
   logic [PORTS-1:0] alarm_reg;
   logic [PORTS-1:0] alarm_set;
   logic [PORTS-1:0] alarm_next;
   logic alarm_read;

   assign alarm_read = reg_rd && (reg_addr == PBOP_OFS_ALARM);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         clk_cfg_reg <= {PORTS{PBOP_RST_CLK}};
         fmt_reg <= {PORTS{PBOP_RST_FMT}};
         sync_reg <= PBOP_RST_SYNC;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            PBOP_OFS_CLK0: clk_cfg_reg[0] <= reg_wdata[6:0];
            PBOP_OFS_CLK1: clk_cfg_reg[1] <= reg_wdata[6:0];
            PBOP_OFS_FMT0: fmt_reg[0] <= reg_wdata[5:0];
            PBOP_OFS_FMT1: fmt_reg[1] <= reg_wdata[5:0];
            PBOP_OFS_SYNC: sync_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // A new error in the clearing read survives it
   always_comb
   begin
      alarm_next = alarm_reg;
      if (alarm_read)
         alarm_next = '0;
      alarm_next = alarm_next | alarm_set;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         alarm_reg <= PBOP_RST_ALARM;
      else
         alarm_reg <= alarm_next;
   end

   // ****************************************************************
   // Read port; answer one cycle after the read strobe
   // ****************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            PBOP_OFS_CLK0: reg_rdata <= {1'b0, clk_cfg_reg[0]};
            PBOP_OFS_CLK1: reg_rdata <= {1'b0, clk_cfg_reg[1]};
            PBOP_OFS_FMT0: reg_rdata <= {2'b00, fmt_reg[0]};
            PBOP_OFS_FMT1: reg_rdata <= {2'b00, fmt_reg[1]};
            PBOP_OFS_SYNC: reg_rdata <= sync_reg;
            PBOP_OFS_ALARM: reg_rdata <= {6'h00, alarm_reg};
            default: reg_rdata <= '0;
         endcase
      end
   end

   // ****************************************************************
   // One serial engine per port
   // ****************************************************************
   for (genvar p = 0; p < PORTS; p++)
   begin : g_port
      pbop_byte_s pend_reg;
      logic pend_valid_reg;
      logic [PBOP_UNIT_MAX-1:0] shift_reg;
      logic [PBOP_LEN_W-1:0] rem_reg;
      logic active_reg;
      logic early_done_reg;
      logic data_reg;
      logic err_reg;
      logic byte_str_reg;
      logic chan_str_reg;
      logic tdm_str_reg;
      logic [PBOP_UNIT_MAX-1:0] unit_bits;
      logic [PBOP_LEN_W-1:0] unit_len;
      logic change_en;
      logic run;
      logic want_early;
      logic do_shift;
      logic do_load;
      logic do_lead;
      logic last_next;
      logic clk_out;

      pbop_unit_builder u_unit (
         .fmt(fmt_reg[p]),
         .byte_in(pend_reg),
         .unit_bits(unit_bits),
         .unit_len(unit_len)
      );

      // Gated clock stops after the falling edge that ends the stream
      assign run = clk_cfg_reg[p].bit_clock_free_run || active_reg || pend_valid_reg;

      pbop_bit_clock u_clk (
         .clk_sys(clk_sys),
         .rst(rst),
         .divisor(clk_cfg_reg[p].bit_clock_divisor),
         .invert(clk_cfg_reg[p].bit_clock_invert),
         .run(run),
         .bit_clock(clk_out),
         .change_en(change_en),
         .sample_en()
      );

      // Pending byte holds one unit ahead so early strobes can look at it
      assign byte_ready[p] = !pend_valid_reg;

      assign want_early = sync_reg[p].byte_strobe_timing
                          || (sync_reg[p].channel_strobe_timing && pend_reg.first_prc)
                          || (sync_reg[p].tdm_strobe_timing && pend_reg.first_tdm);
      assign do_shift = change_en && active_reg && (rem_reg > 4'h1);
      assign do_load = change_en && !do_shift && pend_valid_reg
                       && (early_done_reg || !want_early);
      assign do_lead = change_en && !do_shift && pend_valid_reg && !do_load;
      assign last_next = do_shift && (rem_reg == 4'h2);

      always_ff @(posedge clk_sys)
      begin
         if (rst)
         begin
            pend_reg <= '0;
            pend_valid_reg <= 1'b0;
         end
         else if (byte_valid[p] && !pend_valid_reg)
         begin
            pend_reg <= byte_in[p];
            pend_valid_reg <= 1'b1;
         end
         else if (do_load)
            pend_valid_reg <= 1'b0;
      end

      // Shift path moves only on the non-sampling edge
      always_ff @(posedge clk_sys)
      begin
         if (rst)
         begin
            shift_reg <= '0;
            rem_reg <= '0;
            active_reg <= 1'b0;
            data_reg <= 1'b0;
            err_reg <= 1'b0;
         end
         else if (do_shift)
         begin
            shift_reg <= shift_reg >> 1;
            data_reg <= shift_reg[1];
            rem_reg <= rem_reg - 4'h1;
         end
         else if (do_load)
         begin
            shift_reg <= unit_bits;
            data_reg <= unit_bits[0];
            rem_reg <= unit_len;
            active_reg <= 1'b1;
            err_reg <= pend_reg.error;
         end
         else if (change_en)
         begin
            active_reg <= 1'b0;
            data_reg <= 1'b0;
            rem_reg <= '0;
         end
      end

      // ****************************************************************
      // Strobes, each one bit period wide
      // ****************************************************************
      always_ff @(posedge clk_sys)
      begin
         if (rst)
         begin
            byte_str_reg <= 1'b0;
            chan_str_reg <= 1'b0;
            tdm_str_reg <= 1'b0;
            early_done_reg <= 1'b0;
         end
         else if (change_en)
         begin
            byte_str_reg <= 1'b0;
            chan_str_reg <= 1'b0;
            tdm_str_reg <= 1'b0;
            if (do_load)
            begin
               early_done_reg <= 1'b0;
               byte_str_reg <= !sync_reg[p].byte_strobe_timing;
               chan_str_reg <= !sync_reg[p].channel_strobe_timing && pend_reg.first_prc;
               tdm_str_reg <= !sync_reg[p].tdm_strobe_timing && pend_reg.first_tdm;
            end
            else if (do_lead || (last_next && pend_valid_reg))
            begin
               // No gap between units unless the next byte arrives late
               early_done_reg <= 1'b1;
               byte_str_reg <= sync_reg[p].byte_strobe_timing;
               chan_str_reg <= sync_reg[p].channel_strobe_timing && pend_reg.first_prc;
               tdm_str_reg <= sync_reg[p].tdm_strobe_timing && pend_reg.first_tdm;
            end
         end
      end

      assign alarm_set[p] = do_load && pend_reg.error;

      always_comb
      begin
         port_pins[p].bit_clock = clk_out;
         port_pins[p].data = data_reg;
         port_pins[p].byte_strobe = byte_str_reg;
         port_pins[p].channel_frame_strobe = chan_str_reg;
         port_pins[p].tdm_frame_strobe = tdm_str_reg;
         port_pins[p].frame_sync_or_error_pin = sync_reg[p].sync_error_pin_select ?
                                                err_reg : tdm_str_reg;
      end
   end

endmodule : pbop_output_port
`default_nettype wire

// File: verif/pbop_output_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pbop_output_port_monitor
   import pbop_pkg::*;
#(
   parameter int unsigned PORTS = PBOP_PORTS
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [PBOP_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [PBOP_DATA_W-1:0] reg_wdata,
   input wire logic [PBOP_DATA_W-1:0] reg_rdata,
   input wire logic [PORTS-1:0] byte_valid,
   input wire logic [PORTS-1:0] byte_ready,
   input wire pbop_pkg::pbop_byte_s [PORTS-1:0] byte_in,
   input wire pbop_pkg::pbop_pins_s [PORTS-1:0] port_pins
);
   // ****
   // Port 0 shadows plus the shared sync register
   // ****
   logic [6:0] clk_reg;
   logic [7:0] sync_reg;
   logic bc_reg;
   logic [5:0] hold_reg;
   logic [6:0] bs_reg;
   logic [5:0] half;
   logic bc;
   logic idle;
   assign bc = port_pins[0].bit_clock;
   assign half = {1'b0, clk_reg[6:2]} + 6'h01;
   assign idle = (byte_ready == '1) && (byte_valid == '0);
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         clk_reg <= PBOP_RST_CLK;
         sync_reg <= PBOP_RST_SYNC;
      end
      else if (reg_wr && reg_addr == PBOP_OFS_CLK0)
         clk_reg <= reg_wdata[6:0];
      else if (reg_wr && reg_addr == PBOP_OFS_SYNC)
         sync_reg <= reg_wdata;
   end
   // A new clock setting voids the half period in flight
   always_ff @(posedge clk_sys)
   begin
      bc_reg <= bc;
      if (rst || (reg_wr && reg_addr == PBOP_OFS_CLK0))
         hold_reg <= 6'h3f;
      else if (bc != bc_reg)
         hold_reg <= 6'h01;
      else if (hold_reg != 6'h3f)
         hold_reg <= hold_reg + 6'h01;
   end
   always_ff @(posedge clk_sys)
   begin
      if (rst || !port_pins[0].byte_strobe)
         bs_reg <= 7'h00;
      else if (bs_reg != 7'h7f)
         bs_reg <= bs_reg + 7'h01;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_half_period:
   assert property ((bc != bc_reg) |-> hold_reg >= half)
      else $error("bit clock half period too short");
   a_free_toggle:
   assert property (clk_reg[0] && hold_reg == half |-> bc != bc_reg)
      else $error("free running clock missed a toggle");
   a_pin_sync0:
   assert property (!sync_reg[3] |-> port_pins[0].frame_sync_or_error_pin
      == port_pins[0].tdm_frame_strobe)
      else $error("port 0 shared pin not showing frame sync");
   a_pin_sync1:
   assert property (!sync_reg[7] |-> port_pins[1].frame_sync_or_error_pin
      == port_pins[1].tdm_frame_strobe)
      else $error("port 1 shared pin not showing frame sync");
   a_strobe_width:
   assert property ($fell(port_pins[0].byte_strobe) |-> bs_reg == {half, 1'b0})
      else $error("byte strobe not one bit period wide");
   a_data_phase:
   assert property ($changed(port_pins[0].data) |-> bc == clk_reg[1])
      else $error("data changed on the sampling edge");
   a_strobe_phase:
   assert property ($changed(port_pins[0].byte_strobe) |-> bc == clk_reg[1])
      else $error("strobe changed on the sampling edge");
   a_ready_drop:
   assert property (byte_valid[0] && byte_ready[0] |=> !byte_ready[0])
      else $error("ready stayed high after a byte was taken");
   a_alarm_clear:
   assert property ((reg_rd && reg_addr == PBOP_OFS_ALARM && idle) ##1 idle ##1
      (reg_rd && reg_addr == PBOP_OFS_ALARM && idle) |=> reg_rdata[1:0] == 2'h0)
      else $error("alarm survived a read");
   a_unmapped_read:
   assert property (reg_rd && reg_addr == 16'h0505 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : pbop_output_port_monitor

bind pbop_output_port pbop_output_port_monitor #(.PORTS(PORTS)) u_mon (.clk_sys(clk_sys),
   .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .byte_valid(byte_valid), .byte_ready(byte_ready),
   .byte_in(byte_in), .port_pins(port_pins));
`default_nettype wire

// File: verif/pbop_rx_model.sv
`timescale 1ns/10ps
`default_nettype none
module pbop_rx_model
   import pbop_pkg::*;
(
   input wire pbop_pkg::pbop_pins_s pins,
   input wire logic clk_sys,
   input wire logic invert,
   input wire logic clear,
   output logic [15:0] rx_bits,
   output logic [15:0] bs_mask,
   output logic [15:0] cs_mask,
   output logic [15:0] ts_mask,
   output logic [15:0] ef_mask,
   output logic [4:0] rx_cnt
);
   // Samples on the rising true clock, half a bit after the lines moved
   logic lvl_reg;
   logic lvl;
   assign lvl = pins.bit_clock ^ invert;
   always_ff @(posedge clk_sys)
   begin
      lvl_reg <= lvl;
      if (clear)
      begin
         rx_bits <= 16'h0000;
         bs_mask <= 16'h0000;
         cs_mask <= 16'h0000;
         ts_mask <= 16'h0000;
         ef_mask <= 16'h0000;
         rx_cnt <= 5'h00;
      end
      else if (lvl && !lvl_reg)
      begin
         rx_bits <= {rx_bits[14:0], pins.data};
         bs_mask <= {bs_mask[14:0], pins.byte_strobe};
         cs_mask <= {cs_mask[14:0], pins.channel_frame_strobe};
         ts_mask <= {ts_mask[14:0], pins.tdm_frame_strobe};
         ef_mask <= {ef_mask[14:0], pins.frame_sync_or_error_pin};
         rx_cnt <= rx_cnt + 5'h01;
      end
   end
endmodule : pbop_rx_model
`default_nettype wire

// File: verif/test_payload_bitstream_output_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_payload_bitstream_output_port;
   import pbop_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [1:0] byte_valid = 2'h0;
   logic [1:0] byte_ready;
   pbop_byte_s [1:0] byte_in = '0;
   pbop_pins_s [1:0] port_pins;
   logic [1:0] inv = 2'h0;
   logic clr = 1'b0;
   logic [15:0] rxb [2];
   logic [15:0] bsm [2];
   logic [15:0] csm [2];
   logic [15:0] tsm [2];
   logic [15:0] efm [2];
   logic [4:0] cnt [2];
   int err_total = 0;
   int checks = 0;
   int t;
   logic [7:0] fmt_tab [6] = '{8'h1b, 8'h2e, 8'h3a, 8'h08, 8'h18, 8'h06};
   logic [10:0] byte_tab [6] = '{11'h01c, 11'h01a, 11'h01c, 11'h01e, 11'h40a, 11'h008};
   logic [4:0] len_tab [6] = '{5'h0a, 5'h0a, 5'h0a, 5'h09, 5'h09, 5'h09};
   logic [15:0] exp_tab [6] = '{16'h0301, 16'h000f, 16'h000c, 16'h0006, 16'h0102, 16'h0002};

   always #20 clk_sys = ~clk_sys;

   pbop_output_port #(.PORTS(2)) dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_in(byte_in),
      .port_pins(port_pins));

   for (genvar g = 0; g < 2; g++)
   begin : g_rx
      pbop_rx_model rx (.pins(port_pins[g]), .clk_sys(clk_sys), .invert(inv[g]),
         .clear(clr), .rx_bits(rxb[g]), .bs_mask(bsm[g]), .cs_mask(csm[g]),
         .ts_mask(tsm[g]), .ef_mask(efm[g]), .rx_cnt(cnt[g]));
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk($sformatf("register %h", a), {8'h00, reg_rdata}, {8'h00, exp});
   endtask : rdc

   task automatic send(input int p, input logic [10:0] b);
      int n;
      @(negedge clk_sys);
      byte_in[p] = b;
      byte_valid[p] = 1'b1;
      n = 0;
      while (byte_ready[p] !== 1'b1 && n < 500)
      begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      byte_valid[p] = 1'b0;
   endtask : send

   task automatic unit(input int p, input logic [10:0] b, input logic [4:0] n,
      input logic [15:0] exp, input logic [15:0] bs);
      int k;
      @(negedge clk_sys);
      clr = 1'b1;
      @(negedge clk_sys);
      clr = 1'b0;
      // Units go out one at a time, far apart, as software spaces channels
      send(p, b);
      k = 0;
      while (cnt[p] !== n && k < 2000)
      begin
         @(negedge clk_sys);
         k++;
      end
      // Extra wait exposes surplus bits such as an unwanted parity bit
      repeat (40) @(negedge clk_sys);
      chk("bit count", {11'h000, cnt[p]}, {11'h000, n});
      chk("serial bits", rxb[p], exp);
      chk("byte strobe", bsm[p], bs);
   endtask : unit

   task automatic toggles(input int cyc, output int tg);
      logic prev;
      tg = 0;
      prev = port_pins[0].bit_clock;
      repeat (cyc)
      begin
         @(negedge clk_sys);
         if (port_pins[0].bit_clock !== prev)
            tg++;
         prev = port_pins[0].bit_clock;
      end
   endtask : toggles

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   // Whole run needs well under 10000 cycles
   initial
   begin
      #800000;
      err_total++;
      $display("watchdog expired");
      conclude();
   end

   initial
   begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      for (int i = 0; i < 7; i++)
         rdc(16'h0500 + 16'(i), (i == 4) ? 8'h77 : 8'h00);
      wr(16'h0500, 8'hff);
      rdc(16'h0500, 8'h7f);
      wr(16'h0503, 8'hff);
      rdc(16'h0503, 8'h3f);
      rdc(16'h0502, 8'h00);
      $display("register test done");
      wr(16'h0500, 8'h04);
      wr(16'h0502, 8'h00);
      wr(16'h0504, 8'h00);
      unit(0, 11'h52e, 5'h08, 16'h00a5, 16'h0080);
      chk("channel strobe", csm[0], 16'h0080);
      chk("tdm strobe", tsm[0], 16'h0080);
      for (int i = 0; i < 6; i++)
      begin
         wr(16'h0502, fmt_tab[i]);
         unit(0, byte_tab[i], len_tab[i], exp_tab[i], 16'h0001 << (len_tab[i] - 5'h01));
      end
      $display("format test done");
      wr(16'h0502, 8'h00);
      wr(16'h0504, 8'h07);
      unit(0, 11'h52e, 5'h09, 16'h00a5, 16'h0100);
      chk("channel strobe", csm[0], 16'h0100);
      chk("tdm strobe", tsm[0], 16'h0100);
      $display("early strobe test done");
      wr(16'h0504, 8'h00);
      wr(16'h0500, 8'h06);
      inv[0] = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk("idle clock", {15'h0000, port_pins[0].bit_clock}, 16'h0001);
      unit(0, 11'h52e, 5'h08, 16'h00a5, 16'h0080);
      inv[0] = 1'b0;
      wr(16'h0500, 8'h0d);
      toggles(80, t);
      chk("free toggles", 16'(t), 16'h0014);
      wr(16'h0500, 8'h0c);
      repeat (20) @(negedge clk_sys);
      toggles(40, t);
      chk("gated toggles", 16'(t), 16'h0000);
      $display("clock test done");
      wr(16'h0501, 8'h00);
      wr(16'h0503, 8'h00);
      wr(16'h0504, 8'h80);
      rdc(16'h0506, 8'h00);
      unit(1, 11'h1e1, 5'h08, 16'h003c, 16'h0080);
      chk("error pin", efm[1], 16'h00ff);
      rdc(16'h0506, 8'h02);
      rdc(16'h0506, 8'h00);
      $display("alarm test done");
      conclude();
   end
endmodule : test_payload_bitstream_output_port
`default_nettype wire
